/* File: design/sfr_indirect_addressing.sv */
`timescale 1ns/1ns
// What this block does
// RULE1 - indirect ports redirect to pointed memory
// RULE2 - direct port read gives 00H, write ignored
// RULE3 - first indirect port reaches sector zero only
// RULE4 - other ports: sector high byte, offset low
// RULE5 - five pointers are ordinary readable writable registers
// RULE6 - extended address: upper bits sector, low offset
// RULE7 - bank bit chooses program bank for branches
// RULE8 - bank register upper bits zero, resets zero
// RULE9 - pc low write jumps within current page
// RULE10 - pc low write inserts one dummy cycle
// RULE11 - table read uses pointers, high byte kept
// RULE12 - 55H then AAH enables option mapping
// RULE13 - mapped last page C0H-FFH shows option words
// RULE14 - software writes both keys back to back
// RULE15 - mapping ends after four low-speed periods
// RULE16 - each good pair restarts the timeout
// RULE17 - wake from idle clears unlock register
// RULE18 - wrong pair leaves mapping off
module sfr_indirect_addressing #(
  parameter int OSC_CYCLES = 3125,
  parameter logic [7:0] LAST_PAGE = 8'hFF
)(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [10:0] dm_addr_i,
  input wire logic dm_rd_i,
  input wire logic dm_wr_i,
  input wire logic [7:0] dm_wdata_i,
  output logic [7:0] dm_rdata_o,
  input wire logic [7:0] pc_low_i,
  output logic pc_load_o,
  output logic [7:0] pc_low_o,
  output logic stall_o,
  output logic bank_o,
  input wire logic tbl_rd_i,
  input wire logic tbl_last_i,
  output logic prog_rd_o,
  output logic [15:0] prog_addr_o,
  input wire logic [15:0] prog_data_i,
  output logic opt_rd_o,
  output logic [5:0] opt_addr_o,
  input wire logic [15:0] opt_data_i,
  output logic tbl_done_o,
  output logic [7:0] tbl_low_o,
  output logic map_en_o,
  input wire logic wake_i
);
  // ============================================================
  // storage
  logic [7:0] pointer_sector_zero;
  logic [7:0] pointer_one_low;
  logic [7:0] pointer_one_high;
  logic [7:0] pointer_two_low;
  logic [7:0] pointer_two_high;
  logic [7:0] table_pointer_low;
  logic [7:0] table_pointer_high;
  logic [7:0] table_read_high_byte;
  logic program_bank_select;
  logic [7:0] gp_ram [0:1023];
  logic tbl_wait;
  logic tbl_from_opt;
  logic [7:0] unlock_value;
  logic slow_tick;
  logic map_restart;

  function automatic logic sfr_hit(input logic [10:0] a, input logic [7:0] ofs);
    sfr_hit = (a == {sfr_pkg::SECTOR_ZERO, ofs});
  endfunction

  // ============================================================
  // address resolution
  wire [10:0] eff_addr =
    sfr_hit(dm_addr_i, sfr_pkg::OFS_IND_ZERO) ?
      {sfr_pkg::SECTOR_ZERO, pointer_sector_zero} : // RULE3
    sfr_hit(dm_addr_i, sfr_pkg::OFS_IND_ONE) ?
      {pointer_one_high[2:0], pointer_one_low} : // RULE4
    sfr_hit(dm_addr_i, sfr_pkg::OFS_IND_TWO) ?
      {pointer_two_high[2:0], pointer_two_low} : // RULE4
    dm_addr_i; // RULE6
  // an indirect port reached through a pointer is a plain direct access
  wire is_ram = eff_addr[7]; // RULE1
  wire [9:0] ram_idx = {eff_addr[10:8], eff_addr[6:0]}; // RULE6
  wire wr_ptr0 = dm_wr_i && sfr_hit(eff_addr, sfr_pkg::OFS_PTR_ZERO);
  wire wr_p1l = dm_wr_i && sfr_hit(eff_addr, sfr_pkg::OFS_PTR_ONE_LOW);
  wire wr_p1h = dm_wr_i && sfr_hit(eff_addr, sfr_pkg::OFS_PTR_ONE_HIGH);
  wire wr_p2l = dm_wr_i && sfr_hit(eff_addr, sfr_pkg::OFS_PTR_TWO_LOW);
  wire wr_p2h = dm_wr_i && sfr_hit(eff_addr, sfr_pkg::OFS_PTR_TWO_HIGH);
  wire wr_tbl_low = dm_wr_i && sfr_hit(eff_addr, sfr_pkg::OFS_TBL_LOW);
  wire wr_tbl_high = dm_wr_i && sfr_hit(eff_addr, sfr_pkg::OFS_TBL_HIGH);
  wire wr_bank = dm_wr_i && sfr_hit(eff_addr, sfr_pkg::OFS_BANK);
  wire wr_pc = dm_wr_i && sfr_hit(eff_addr, sfr_pkg::OFS_PC_LOW);
  wire wr_unlock = dm_wr_i && sfr_hit(eff_addr, sfr_pkg::OFS_UNLOCK);
  wire is_ind_direct = sfr_hit(eff_addr, sfr_pkg::OFS_IND_ZERO)
    || sfr_hit(eff_addr, sfr_pkg::OFS_IND_ONE)
    || sfr_hit(eff_addr, sfr_pkg::OFS_IND_TWO);

  // ============================================================
  // read selection; unlisted locations read as zero
  wire [7:0] bank_read = {7'h00, program_bank_select}; // RULE8
  wire [7:0] rd_val =
    is_ram ? gp_ram[ram_idx] :
    sfr_hit(eff_addr, sfr_pkg::OFS_PTR_ZERO) ? pointer_sector_zero : // RULE5
    sfr_hit(eff_addr, sfr_pkg::OFS_PTR_ONE_LOW) ? pointer_one_low :
    sfr_hit(eff_addr, sfr_pkg::OFS_PTR_ONE_HIGH) ? pointer_one_high :
    sfr_hit(eff_addr, sfr_pkg::OFS_PTR_TWO_LOW) ? pointer_two_low :
    sfr_hit(eff_addr, sfr_pkg::OFS_PTR_TWO_HIGH) ? pointer_two_high :
    sfr_hit(eff_addr, sfr_pkg::OFS_PC_LOW) ? pc_low_i :
    sfr_hit(eff_addr, sfr_pkg::OFS_TBL_LOW) ? table_pointer_low :
    sfr_hit(eff_addr, sfr_pkg::OFS_TBL_HIGH) ? table_pointer_high :
    sfr_hit(eff_addr, sfr_pkg::OFS_TBL_READ_HIGH) ? table_read_high_byte :
    sfr_hit(eff_addr, sfr_pkg::OFS_BANK) ? bank_read :
    sfr_hit(eff_addr, sfr_pkg::OFS_UNLOCK) ? unlock_value :
    sfr_pkg::READ_ZERO; // RULE2

  // ============================================================
  // table read address and option window
  wire [7:0] tbl_page = tbl_last_i ? LAST_PAGE : table_pointer_high;
  wire tbl_opt = map_en_o && (tbl_page == LAST_PAGE)
    && (table_pointer_low >= sfr_pkg::OPT_WINDOW_BASE); // RULE13
  wire [15:0] tbl_word = tbl_from_opt ? opt_data_i : prog_data_i;

  // ============================================================
  // data memory; no reset, contents are undefined at power-up
  always_ff @(posedge clk_i)
  begin
    if (dm_wr_i && is_ram)
      gp_ram[ram_idx] <= dm_wdata_i; // RULE1
  end

  // ============================================================
  // pointers and control registers
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pointer_sector_zero <= sfr_pkg::REG_RESET;
      pointer_one_low <= sfr_pkg::REG_RESET;
      pointer_one_high <= sfr_pkg::REG_RESET;
      pointer_two_low <= sfr_pkg::REG_RESET;
      pointer_two_high <= sfr_pkg::REG_RESET;
      table_pointer_low <= sfr_pkg::REG_RESET;
      table_pointer_high <= sfr_pkg::REG_RESET;
      program_bank_select <= 1'b0; // RULE8
    end
    else
    begin
      // increment and decrement arrive as read then write by the core
      if (wr_ptr0) pointer_sector_zero <= dm_wdata_i; // RULE5
      if (wr_p1l) pointer_one_low <= dm_wdata_i; // RULE5
      if (wr_p1h) pointer_one_high <= dm_wdata_i; // RULE5
      if (wr_p2l) pointer_two_low <= dm_wdata_i; // RULE5
      if (wr_p2h) pointer_two_high <= dm_wdata_i; // RULE5
      if (wr_tbl_low) table_pointer_low <= dm_wdata_i;
      if (wr_tbl_high) table_pointer_high <= dm_wdata_i;
      if (wr_bank) program_bank_select <= dm_wdata_i[sfr_pkg::BANK_SEL_BIT]; // RULE7
    end
  end

  // ============================================================
  // core-facing outputs
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      dm_rdata_o <= sfr_pkg::READ_ZERO;
      pc_load_o <= 1'b0;
      pc_low_o <= sfr_pkg::REG_RESET;
      stall_o <= 1'b0;
      bank_o <= 1'b0;
    end
    else
    begin
      if (dm_rd_i) dm_rdata_o <= rd_val;
      pc_load_o <= wr_pc; // RULE9
      stall_o <= wr_pc; // RULE10
      if (wr_pc) pc_low_o <= dm_wdata_i; // RULE9
      bank_o <= wr_bank ? dm_wdata_i[sfr_pkg::BANK_SEL_BIT] : program_bank_select; // RULE7
    end
  end

  // ============================================================
  // table read: fetch in one cycle, result in the next
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      prog_rd_o <= 1'b0;
      opt_rd_o <= 1'b0;
      prog_addr_o <= 16'h0000;
      opt_addr_o <= 6'h00;
      tbl_wait <= 1'b0;
      tbl_from_opt <= 1'b0;
      tbl_done_o <= 1'b0;
      tbl_low_o <= sfr_pkg::REG_RESET;
      table_read_high_byte <= sfr_pkg::REG_RESET;
    end
    else
    begin
      prog_rd_o <= tbl_rd_i && !tbl_opt; // RULE18
      opt_rd_o <= tbl_rd_i && tbl_opt; // RULE13
      if (tbl_rd_i)
      begin
        prog_addr_o <= {tbl_page, table_pointer_low}; // RULE11
        opt_addr_o <= table_pointer_low[5:0]; // RULE13
        tbl_from_opt <= tbl_opt;
      end
      tbl_wait <= tbl_rd_i;
      tbl_done_o <= tbl_wait;
      if (tbl_wait)
      begin
        table_read_high_byte <= tbl_word[15:8]; // RULE11
        tbl_low_o <= tbl_word[7:0]; // RULE11
      end
    end
  end

  // ============================================================
  // option mapping unlock and timeout
  slow_tick_gen #(.OSC_CYCLES(OSC_CYCLES)) u_tick (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(map_restart),
    .tick_o(slow_tick)
  );

  option_map_unlock u_unlock (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_i(wr_unlock),
    .wdata_i(dm_wdata_i),
    .wake_i(wake_i),
    .tick_i(slow_tick),
    .value_o(unlock_value),
    .restart_o(map_restart),
    .map_en_o(map_en_o)
  );

  // ============================================================
  // checks
  property p_ind_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
    (dm_rd_i && is_ind_direct) |=> (dm_rdata_o == sfr_pkg::READ_ZERO);
  endproperty
  a_ind_zero: assert property (p_ind_zero) else $error("direct port read not zero"); // RULE2

  property p_sector_zero;
    @(posedge clk_i) disable iff (sys_rst_i)
    sfr_hit(dm_addr_i, sfr_pkg::OFS_IND_ZERO) |-> (eff_addr[10:8] == sfr_pkg::SECTOR_ZERO);
  endproperty
  a_sector_zero: assert property (p_sector_zero) else $error("port zero left sector 0"); // RULE3

  property p_bank;
    @(posedge clk_i) disable iff (sys_rst_i)
    wr_bank |=> (bank_o == $past(dm_wdata_i[0])) && (bank_read == {7'h00, bank_o});
  endproperty
  a_bank: assert property (p_bank) else $error("bank select not taken"); // RULE7

  property p_bank_upper;
    @(posedge clk_i) disable iff (sys_rst_i)
    (dm_rd_i && sfr_hit(eff_addr, sfr_pkg::OFS_BANK)) |=> (dm_rdata_o[7:1] == 7'h00);
  endproperty
  a_bank_upper: assert property (p_bank_upper) else $error("bank upper bits set"); // RULE8

  property p_pc_jump;
    @(posedge clk_i) disable iff (sys_rst_i)
    wr_pc |=> (pc_load_o && stall_o && pc_low_o == $past(dm_wdata_i))
      ##1 (!stall_o || $past(wr_pc));
  endproperty
  a_pc_jump: assert property (p_pc_jump) else $error("pc low jump wrong"); // RULE10

  property p_tbl_high;
    @(posedge clk_i) disable iff (sys_rst_i)
    prog_rd_o |=> (tbl_done_o && table_read_high_byte == $past(prog_data_i[15:8]));
  endproperty
  a_tbl_high: assert property (p_tbl_high) else $error("table high byte wrong"); // RULE11

  property p_opt_window;
    @(posedge clk_i) disable iff (sys_rst_i)
    (tbl_rd_i && tbl_opt) |=> (opt_rd_o && !prog_rd_o && opt_addr_o == $past(table_pointer_low[5:0]));
  endproperty
  a_opt_window: assert property (p_opt_window) else $error("option window missed"); // RULE13

  property p_no_map;
    @(posedge clk_i) disable iff (sys_rst_i)
    (tbl_rd_i && !map_en_o) |=> (prog_rd_o && !opt_rd_o);
  endproperty
  a_no_map: assert property (p_no_map) else $error("option read while unmapped"); // RULE18

  property p_opt_word;
    @(posedge clk_i) disable iff (sys_rst_i)
    opt_rd_o |=> (tbl_done_o && tbl_low_o == $past(opt_data_i[7:0])
      && table_read_high_byte == $past(opt_data_i[15:8]));
  endproperty
  a_opt_word: assert property (p_opt_word) else $error("option word not returned"); // RULE13

  property p_ram_write;
    @(posedge clk_i) disable iff (sys_rst_i)
    (dm_wr_i && is_ram) |=> (gp_ram[$past(ram_idx)] == $past(dm_wdata_i));
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("memory write lost"); // RULE1

  property p_pc_only;
    @(posedge clk_i) disable iff (sys_rst_i)
    !wr_pc |=> !pc_load_o;
  endproperty
  a_pc_only: assert property (p_pc_only) else $error("pc load without write"); // RULE9
endmodule

/* File: design/sfr_pkg.sv */
package sfr_pkg;
  // ============================================================
  // sector 0 special function register offsets
  localparam logic [7:0] OFS_IND_ZERO = 8'h00;
  localparam logic [7:0] OFS_PTR_ZERO = 8'h01;
  localparam logic [7:0] OFS_IND_ONE = 8'h02;
  localparam logic [7:0] OFS_PTR_ONE_LOW = 8'h03;
  localparam logic [7:0] OFS_PTR_ONE_HIGH = 8'h04;
  localparam logic [7:0] OFS_PC_LOW = 8'h06;
  localparam logic [7:0] OFS_TBL_LOW = 8'h07;
  localparam logic [7:0] OFS_TBL_READ_HIGH = 8'h08;
  localparam logic [7:0] OFS_TBL_HIGH = 8'h09;
  localparam logic [7:0] OFS_BANK = 8'h0B;
  localparam logic [7:0] OFS_IND_TWO = 8'h0C;
  localparam logic [7:0] OFS_PTR_TWO_LOW = 8'h0D;
  localparam logic [7:0] OFS_PTR_TWO_HIGH = 8'h0E;
  localparam logic [7:0] OFS_UNLOCK = 8'h12;
  // ============================================================
  // fields, reset values and keys
  localparam int BANK_SEL_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
  localparam logic [7:0] OPT_WINDOW_BASE = 8'hC0;
  localparam logic [2:0] SECTOR_ZERO = 3'h0;
  // ============================================================
  // timing: mapping lasts this many low-speed oscillator periods
  localparam int MAP_PERIODS = 4;
  localparam logic [2:0] MAP_LAST_PERIOD = 3'(MAP_PERIODS - 1);
endpackage

/* File: design/low_speed_internal_osc_tick_gen.sv */
`timescale 1ns/1ns
module slow_tick_gen #(
  parameter int OSC_CYCLES = 3125
)(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic restart_i,
  output logic tick_o
);
  // ============================================================
  // low-speed period as a one-cycle enable; restart realigns phase
  logic [15:0] count;
  localparam logic [15:0] LAST = 16'(OSC_CYCLES - 1);
  wire wrap = (count == LAST);

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      count <= 16'h0000;
      tick_o <= 1'b0;
    end
    else
    begin
      count <= (restart_i || wrap) ? 16'h0000 : count + 16'h0001;
      tick_o <= wrap && !restart_i;
    end
  end
endmodule

/* File: design/option_map_unlock.sv */
`timescale 1ns/1ns
module option_map_unlock (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wake_i,
  input wire logic tick_i,
  output logic [7:0] value_o,
  output logic restart_o,
  output logic map_en_o
);
  // ============================================================
  // unlock sequence
  logic armed;
  logic [2:0] periods;
  wire pair_ok = wr_i && (wdata_i == sfr_pkg::UNLOCK_KEY_SECOND) && armed; // RULE12
  wire expire = map_en_o && tick_i && (periods == sfr_pkg::MAP_LAST_PERIOD);
  assign restart_o = pair_ok;

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      value_o <= sfr_pkg::REG_RESET;
      armed <= 1'b0;
    end
    else
    begin
      // a write in the wake cycle is kept; the clear only drops stale keys
      if (wr_i)
        value_o <= wdata_i;
      else if (wake_i)
        value_o <= sfr_pkg::REG_RESET; // RULE17
      // key must follow in the very next cycle, anything else disarms
      armed <= wr_i && (wdata_i == sfr_pkg::UNLOCK_KEY_FIRST); // RULE14
    end
  end

  // ============================================================
  // mapping timeout
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      map_en_o <= 1'b0;
      periods <= 3'h0;
    end
    else if (pair_ok)
    begin
      map_en_o <= 1'b1; // RULE12
      periods <= 3'h0; // RULE16
    end
    else if (expire)
    begin
      map_en_o <= 1'b0; // RULE15
    end
    else if (map_en_o && tick_i)
    begin
      periods <= periods + 3'h1; // RULE15
    end
  end

  property p_unlock;
    @(posedge clk_i) disable iff (sys_rst_i)
    (wr_i && wdata_i == sfr_pkg::UNLOCK_KEY_FIRST)
      ##1 (wr_i && wdata_i == sfr_pkg::UNLOCK_KEY_SECOND) |=> map_en_o;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock pair did not map"); // RULE12

  property p_expire;
    @(posedge clk_i) disable iff (sys_rst_i)
    (expire && !pair_ok) |=> !map_en_o;
  endproperty
  a_expire: assert property (p_expire) else $error("mapping outlived timeout"); // RULE15

  property p_bad_pair;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!map_en_o && !(wr_i && wdata_i == sfr_pkg::UNLOCK_KEY_FIRST))
      ##1 (wr_i && !map_en_o) |=> !map_en_o;
  endproperty
  a_bad_pair: assert property (p_bad_pair) else $error("mapping without key pair"); // RULE18
endmodule

/* File: verification/core_mem_model.sv */
`timescale 1ns/1ns
// ============================================================
// program and option memory seen by the table read path
module core_mem_model (
  input wire logic clk_i,
  input wire logic prog_rd_i,
  input wire logic [15:0] prog_addr_i,
  input wire logic opt_rd_i,
  input wire logic [5:0] opt_addr_i,
  output logic [15:0] prog_data_o,
  output logic [15:0] opt_data_o
);
  logic [15:0] junk = 16'h0F0F;
  // idle bus shows a pattern that flips every cycle, so stale data never matches
  always @(posedge clk_i)
  begin
    junk <= ~junk;
  end
  // words derive from the address so a wrong address gives a wrong word
  assign prog_data_o = prog_rd_i ? {prog_addr_i[7:0] ^ 8'h5A, prog_addr_i[15:8]} : junk;
  assign opt_data_o = opt_rd_i ? {8'hC0 | {2'h0, opt_addr_i}, {2'h0, opt_addr_i} ^ 8'h3F} : ~junk;
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb_top;
  localparam int OSC = 4;
  logic clk_i, sys_rst_i, dm_rd_i, dm_wr_i, tbl_rd_i, tbl_last_i, wake_i;
  logic [10:0] dm_addr_i;
  logic [7:0] dm_wdata_i, pc_low_i, dm_rdata_o, pc_low_o, tbl_low_o;
  logic pc_load_o, stall_o, bank_o, prog_rd_o, opt_rd_o, tbl_done_o, map_en_o;
  logic [15:0] prog_addr_o, prog_data_i, opt_data_i;
  logic [5:0] opt_addr_o;
  int err_count, comparisons, n;
  logic [7:0] ofs [10];
  // ============================================================
  // design and memory
  sfr_indirect_addressing #(.OSC_CYCLES(OSC), .LAST_PAGE(8'hFF)) u_sfr_indirect_addressing (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .dm_addr_i(dm_addr_i), .dm_rd_i(dm_rd_i),
    .dm_wr_i(dm_wr_i), .dm_wdata_i(dm_wdata_i), .dm_rdata_o(dm_rdata_o),
    .pc_low_i(pc_low_i), .pc_load_o(pc_load_o), .pc_low_o(pc_low_o), .stall_o(stall_o),
    .bank_o(bank_o), .tbl_rd_i(tbl_rd_i), .tbl_last_i(tbl_last_i), .prog_rd_o(prog_rd_o),
    .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i), .opt_rd_o(opt_rd_o),
    .opt_addr_o(opt_addr_o), .opt_data_i(opt_data_i), .tbl_done_o(tbl_done_o),
    .tbl_low_o(tbl_low_o), .map_en_o(map_en_o), .wake_i(wake_i));
  core_mem_model u_core_mem_model (.clk_i(clk_i), .prog_rd_i(prog_rd_o),
    .prog_addr_i(prog_addr_o), .opt_rd_i(opt_rd_o), .opt_addr_i(opt_addr_o),
    .prog_data_o(prog_data_i), .opt_data_o(opt_data_i));
  // ============================================================
  // access tasks; a write leaves its strobe up so writes can go back to back
  task wr(input logic [10:0] a, input logic [7:0] d);
    dm_addr_i <= a;
    dm_wdata_i <= d;
    dm_wr_i <= 1'b1;
    dm_rd_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task wr0(input logic [7:0] o, input logic [7:0] d);
    wr({3'h0, o}, d);
  endtask
  task rd(input logic [10:0] a, input logic [7:0] e);
    dm_addr_i <= a;
    dm_rd_i <= 1'b1;
    dm_wr_i <= 1'b0;
    @(posedge clk_i);
    dm_rd_i <= 1'b0;
    @(negedge clk_i);
    `CHK("dm_rdata", e, dm_rdata_o)
    @(posedge clk_i);
  endtask
  task rd0(input logic [7:0] o, input logic [7:0] e);
    rd({3'h0, o}, e);
  endtask
  task tbl(input logic last, input logic opt, input logic [15:0] a);
    logic [15:0] w;
    w = opt ? {8'hC0 | {2'h0, a[5:0]}, {2'h0, a[5:0]} ^ 8'h3F} : {a[7:0] ^ 8'h5A, a[15:8]};
    tbl_rd_i <= 1'b1;
    tbl_last_i <= last;
    dm_wr_i <= 1'b0;
    @(posedge clk_i);
    tbl_rd_i <= 1'b0;
    @(negedge clk_i);
    `CHK("prog_rd", !opt, prog_rd_o)
    `CHK("opt_rd", opt, opt_rd_o)
    if (opt)
      `CHK("opt_addr", a[5:0], opt_addr_o)
    else
      `CHK("prog_addr", a, prog_addr_o)
    @(negedge clk_i);
    `CHK("tbl_done", 1'b1, tbl_done_o)
    `CHK("tbl_low", w[7:0], tbl_low_o)
    @(posedge clk_i);
    rd0(sfr_pkg::OFS_TBL_READ_HIGH, w[15:8]);
  endtask
  task unlock;
    wr0(sfr_pkg::OFS_UNLOCK, sfr_pkg::UNLOCK_KEY_FIRST);
    wr0(sfr_pkg::OFS_UNLOCK, sfr_pkg::UNLOCK_KEY_SECOND);
    dm_wr_i <= 1'b0;
    @(negedge clk_i);
    `CHK("map_en", 1'b1, map_en_o)
    @(posedge clk_i);
  endtask
  task end_of_test;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ============================================================
  // clock, watchdog, tests
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    end_of_test;
  end
  initial
  begin
    {sys_rst_i, dm_rd_i, dm_wr_i, tbl_rd_i, tbl_last_i, wake_i} = 6'h20;
    dm_addr_i = 11'h000;
    dm_wdata_i = 8'h00;
    pc_low_i = 8'h33;
    err_count = 0;
    comparisons = 0;
    ofs = '{8'h01, 8'h03, 8'h04, 8'h07, 8'h08, 8'h09, 8'h0B, 8'h0D, 8'h0E, 8'h12};
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("bank", 1'b0, bank_o)
    foreach (ofs[i]) rd0(ofs[i], sfr_pkg::REG_RESET);
    wr0(sfr_pkg::OFS_PTR_ZERO, 8'hF0);
    wr0(sfr_pkg::OFS_PTR_ONE_LOW, 8'hF0);
    wr0(sfr_pkg::OFS_PTR_ONE_HIGH, 8'h01);
    wr0(sfr_pkg::OFS_PTR_TWO_LOW, 8'hF0);
    wr0(sfr_pkg::OFS_PTR_TWO_HIGH, 8'hFA);
    rd0(sfr_pkg::OFS_PTR_TWO_HIGH, 8'hFA);
    rd0(sfr_pkg::OFS_PTR_ONE_LOW, 8'hF0);
    wr(11'h0F0, 8'h77);
    wr(11'h1F0, 8'h3C);
    wr(11'h2F0, 8'h96);
    rd(11'h1F0, 8'h3C);
    rd(11'h000, 8'h77);
    rd(11'h002, 8'h3C);
    rd(11'h00C, 8'h96);
    wr(11'h002, 8'h5B);
    rd(11'h1F0, 8'h5B);
    wr0(sfr_pkg::OFS_PTR_ZERO, sfr_pkg::OFS_IND_ZERO);
    wr(11'h000, 8'hEE);
    rd(11'h000, sfr_pkg::READ_ZERO);
    wr0(sfr_pkg::OFS_PTR_ONE_HIGH, 8'h00);
    wr0(sfr_pkg::OFS_PTR_ONE_LOW, sfr_pkg::OFS_IND_TWO);
    rd(11'h002, sfr_pkg::READ_ZERO);
    wr0(sfr_pkg::OFS_BANK, 8'hFF);
    rd0(sfr_pkg::OFS_BANK, 8'h01);
    `CHK("bank", 1'b1, bank_o)
    wr0(sfr_pkg::OFS_PC_LOW, 8'h5A);
    dm_wr_i <= 1'b0;
    @(negedge clk_i);
    `CHK("pc_load", 2'h3, {pc_load_o, stall_o})
    `CHK("pc_low", 8'h5A, pc_low_o)
    @(negedge clk_i);
    `CHK("pc_load", 2'h0, {pc_load_o, stall_o})
    @(posedge clk_i);
    rd0(sfr_pkg::OFS_PC_LOW, 8'h33);
    wr0(sfr_pkg::OFS_TBL_LOW, 8'h12);
    wr0(sfr_pkg::OFS_TBL_HIGH, 8'h34);
    tbl(1'b0, 1'b0, 16'h3412);
    // wrong second key, then right keys with a gap between them
    wr0(sfr_pkg::OFS_UNLOCK, sfr_pkg::UNLOCK_KEY_FIRST);
    wr0(sfr_pkg::OFS_UNLOCK, 8'h00);
    wr0(sfr_pkg::OFS_TBL_LOW, 8'hC5);
    tbl(1'b1, 1'b0, 16'hFFC5);
    wr0(sfr_pkg::OFS_UNLOCK, sfr_pkg::UNLOCK_KEY_FIRST);
    wr0(sfr_pkg::OFS_TBL_LOW, 8'hC5);
    wr0(sfr_pkg::OFS_UNLOCK, sfr_pkg::UNLOCK_KEY_SECOND);
    tbl(1'b1, 1'b0, 16'hFFC5);
    `CHK("map_en", 1'b0, map_en_o)
    unlock;
    tbl(1'b1, 1'b1, 16'hFFC5);
    wr0(sfr_pkg::OFS_TBL_LOW, 8'hBF);
    tbl(1'b1, 1'b0, 16'hFFBF);
    unlock;
    // the second pair must restart the full span, not inherit the first
    n = 1;
    while (map_en_o === 1'b1 && n < 40)
    begin
      @(posedge clk_i);
      n++;
    end
    `CHK("map_span", 1'b1, (n >= 4 * OSC - 3 && n <= 4 * OSC + 2))
    wr0(sfr_pkg::OFS_TBL_LOW, 8'hC5);
    tbl(1'b1, 1'b0, 16'hFFC5);
    wr0(sfr_pkg::OFS_UNLOCK, 8'h3C);
    rd0(sfr_pkg::OFS_UNLOCK, 8'h3C);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    rd0(sfr_pkg::OFS_UNLOCK, 8'h00);
    end_of_test;
  end
endmodule
